/* File: shared/mps_cfg.svh */
// Constants for the motor protection status and setpoint block
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH
// Timing figures in their own units
`define MPS_CLK_HZ        10_000_000
`define MPS_OVL_LOW_HZ    2
`define MPS_OVL_HIGH_HZ   5
`define MPS_FLICK_HZ      10
`define MPS_SLOW_HZ       1
`define MPS_WDOG_MS       100
`define MPS_FLICK_S       2
`define MPS_PAUSE_S       1
// Setpoint figures in tenths of an ampere
`define MPS_TENTHS_PER_A  8'h0A
`define MPS_DIGIT_MAX     4'h9
`define MPS_SW_MIN        8'h09
`define MPS_REG_MAX       8'h96
// Error code shown when no rated current is set
`define MPS_ERR_CODE      4'h1
`define MPS_ERR_ARG       4'h0
// Settle delay before an apply, covers switch synchroniser
`define MPS_APPLY_DLY     2'h3
`define MPS_CMD_APPLY_BIT 0
// Register byte addresses
`define MPS_ADR_CTRL      8'h00
`define MPS_ADR_CMD       8'h04
`define MPS_ADR_PH1       8'h08
`define MPS_ADR_PH2       8'h0C
`define MPS_ADR_PH3       8'h10
`define MPS_ADR_STAT      8'h14
`define MPS_ADR_EVT       8'h18
`define MPS_ADR_MASK      8'h1C
`endif

/* File: shared/mps_pkg.sv */
// Types for the motor protection status and setpoint block
package mps_pkg;
  typedef logic [24:0] mps_cnt_type;  // Long divider counter
  typedef logic [7:0]  mps_amp_type;  // Current in 0.1 A units
  // Divider state
  typedef struct packed {
    mps_cnt_type cnt;
    logic        lvl;
    logic        tick;
  } mps_blink_state_type;
  // Software motor control
  typedef struct packed {
    logic single_phase;
    logic run_left;
    logic run_right;
  } mps_ctrl_type;
  // Three phase setpoints
  typedef struct packed {
    mps_amp_type ph3;
    mps_amp_type ph2;
    mps_amp_type ph1;
  } mps_sp_type;
  // Indicator set
  typedef struct packed {
    logic motor_on;
    logic overload;
    logic run;
    logic stop;
  } mps_led_type;
  // Flash code sequencer
  typedef enum logic [2:0] {
    FL_IDLE   = 3'b000,
    FL_FLICK  = 3'b001,
    FL_PAUSE1 = 3'b010,
    FL_CODE   = 3'b011,
    FL_PAUSE2 = 3'b100,
    FL_ARG    = 3'b101,
    FL_PAUSE3 = 3'b110
  } mps_flash_type;
  // Whole state of the top block
  typedef struct packed {
    logic [7:0]    sw_meta;
    logic [7:0]    sw_sync;
    mps_ctrl_type  ctrl;
    mps_sp_type    regs;
    mps_sp_type    appl;
    logic          reg_mode;
    logic [1:0]    apply_wait;
    logic          fault;
    logic          trip;
    logic          warn;
    logic          comm_lost;
    mps_cnt_type   wdog;
    logic [3:0]    events;
    logic [3:0]    mask;
    logic [15:0]   rdata;
    mps_flash_type flash;
    logic [3:0]    fcnt;
    logic          fon;
    mps_led_type   led;
    logic          coil_r;
    logic          coil_l;
    logic          irq;
  } mps_state_type;
endpackage : mps_pkg

/* File: testbench/mps_coupler_model.sv */
// Bus coupler model that sends error-free terminal bus frames
`timescale 1ns/1ns
`default_nettype none
module mps_coupler_model (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       enable,
  input  wire logic [7:0] gap,
  output var  logic       bus_frame_ok
);
  logic [7:0] gap_cnt;  // Cycles since the last frame

  // One frame pulse after gap idle cycles; silent while disabled
  always_ff @(posedge clk_sys) begin
    if (!resetn || !enable) begin
      gap_cnt      <= 8'h00;
      bus_frame_ok <= 1'b0;
    end else if (gap_cnt >= gap) begin
      gap_cnt      <= 8'h00;
      bus_frame_ok <= 1'b1;
    end else begin
      gap_cnt      <= gap_cnt + 8'h01;
      bus_frame_ok <= 1'b0;
    end
  end
endmodule : mps_coupler_model
`default_nettype wire

/* File: testbench/mps_top_tb_top.sv */
// Self-checking bench for the motor protection status block
`timescale 1ns/1ns
`default_nettype none
`include "mps_cfg.svh"
module mps_top_tb_top
  import mps_pkg::*;
;
  logic        clk_sys, resetn, overload_trip, load_above_max, load_below_min;
  logic [3:0]  sw_amp, sw_tenth;
  logic [7:0]  cpl_gap;      // Coupler idle cycles between frames
  logic        bus_frame_ok, reg_wr, reg_rd, irq, reg_mode, cpl_en;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        coil_drive_right, coil_drive_left, led_motor_on;
  logic        led_overload, led_run, led_stop, ovl_prev, stop_prev;
  mps_amp_type rated_current_phase_one, rated_current_phase_two;
  mps_amp_type rated_current_phase_three;
  logic [5:0]  outs;         // Coils and indicators in one word
  int          miscompares;  // Failed comparisons
  int          tests_run;    // Comparisons made
  int          ovl_tog;      // Overload indicator edges
  int          stop_tog;     // Stop indicator edges
  int          n;            // Wait counter

  assign outs = {coil_drive_right, coil_drive_left, led_motor_on,
                 led_overload, led_run, led_stop};

  // Clock of 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  mps_top #(.WDOG_CYC(50), .HALF_LOW(10), .HALF_HIGH(4), .HALF_FLK(2), .HALF_SLOW(20))
  mps_top_inst (.clk_sys, .resetn, .sw_amp, .sw_tenth, .overload_trip, .load_above_max,
    .load_below_min, .bus_frame_ok, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .coil_drive_right, .coil_drive_left, .led_motor_on,
    .led_overload, .led_run, .led_stop, .reg_mode, .rated_current_phase_one,
    .rated_current_phase_two, .rated_current_phase_three);

  mps_coupler_model mps_coupler_model_inst (.clk_sys, .resetn, .enable(cpl_en),
    .gap(cpl_gap), .bus_frame_ok);

  // Edge counters for blink rate checks
  always @(posedge clk_sys) begin
    ovl_prev  <= led_overload;
    stop_prev <= led_stop;
    if (led_overload !== ovl_prev) ovl_tog++;
    if (led_stop !== stop_prev) stop_tog++;
  end

  // Value comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Count comparison within a window
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    tests_run++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  // Wait cycles, then let the edge settle
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe, data taken in the following cycle
  task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(nm, 32'(e), 32'(reg_rdata));
  endtask : rc

  // Setpoint re-apply command
  task automatic apply();
    wr(`MPS_ADR_CMD, 16'h0001);
    cyc(4);
  endtask : apply

  // Rotary switch change with synchroniser settle
  task automatic setsw(input logic [3:0] a, input logic [3:0] t);
    @(posedge clk_sys);
    sw_amp   <= a;
    sw_tenth <= t;
    cyc(6);
  endtask : setsw

  // Protection level inputs
  task automatic lv(input logic tr, input logic hi, input logic lo);
    @(posedge clk_sys);
    overload_trip  <= tr;
    load_above_max <= hi;
    load_below_min <= lo;
    cyc(3);
  endtask : lv

  // Applied setpoints and mode
  task automatic sp(input logic m, input mps_amp_type a, input mps_amp_type b,
                    input mps_amp_type c);
    chk("setpoints", {7'h00, m, c, b, a}, {7'h00, reg_mode, rated_current_phase_three,
        rated_current_phase_two, rated_current_phase_one});
  endtask : sp

  // Count indicator edges over k cycles
  task automatic blink(input int k);
    cyc(1);
    ovl_tog  = 0;
    stop_tog = 0;
    cyc(k);
  endtask : blink

  // Final verdict
  task automatic end_sim();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    {resetn, overload_trip, load_above_max, load_below_min, reg_wr, reg_rd} = 6'h00;
    {reg_addr, reg_wdata, ovl_prev, stop_prev} = 26'h000_0000;
    {miscompares, tests_run, ovl_tog, stop_tog} = {4{32'h0000_0000}};
    sw_amp   = 4'h3;
    sw_tenth = 4'h5;
    cpl_en   = 1'b1;
    cpl_gap  = 8'h07;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    cyc(6);
    sp(1'b0, 8'h23, 8'h23, 8'h23);
    chk("outputs", 32'(6'h02), 32'(outs));
    rc("unmapped", 8'h20, 16'h0000);
    $display("test reset done");
    setsw(4'h9, 4'h9);
    sp(1'b0, 8'h23, 8'h23, 8'h23);
    apply();
    sp(1'b0, 8'h63, 8'h63, 8'h63);
    setsw(4'h0, 4'h5);
    apply();
    sp(1'b0, 8'h09, 8'h09, 8'h09);
    $display("test switches done");
    wr(`MPS_ADR_PH1, 16'h0078);
    wr(`MPS_ADR_PH2, 16'h0032);
    wr(`MPS_ADR_PH3, 16'h00C8);
    rc("phase3", `MPS_ADR_PH3, 16'h0096);
    rc("phase1", `MPS_ADR_PH1, 16'h0078);
    setsw(4'h0, 4'h0);
    apply();
    sp(1'b1, 8'h78, 8'h78, 8'h78);
    wr(`MPS_ADR_CTRL, 16'h0004);
    apply();
    sp(1'b1, 8'h78, 8'h32, 8'h96);
    $display("test registers done");
    wr(`MPS_ADR_CTRL, 16'h0005);
    cyc(2);
    chk("outputs", 32'(6'h2A), 32'(outs));
    wr(`MPS_ADR_CTRL, 16'h0006);
    cyc(2);
    chk("outputs", 32'(6'h1A), 32'(outs));
    wr(`MPS_ADR_CTRL, 16'h0007);
    cyc(2);
    chk("outputs", 32'(6'h02), 32'(outs));
    wr(`MPS_ADR_CTRL, 16'h0005);
    rc("ctrl", `MPS_ADR_CTRL, 16'h0005);
    $display("test coils done");
    lv(1'b0, 1'b0, 1'b1);
    blink(200);
    chk_rng("slow blink", 19, 21, ovl_tog);
    lv(1'b0, 1'b1, 1'b1);
    blink(200);
    chk_rng("fast blink", 49, 51, ovl_tog);
    lv(1'b0, 1'b0, 1'b0);
    chk("outputs", 32'(6'h2A), 32'(outs));
    wr(`MPS_ADR_MASK, 16'h0001);
    rc("mask", `MPS_ADR_MASK, 16'h0001);
    lv(1'b1, 1'b1, 1'b0);
    chk("outputs", 32'(6'h06), 32'(outs));
    chk("irq", 32'h0000_0001, 32'(irq));
    lv(1'b0, 1'b0, 1'b0);
    chk("outputs", 32'(6'h06), 32'(outs));
    wr(`MPS_ADR_EVT, 16'h0001);
    cyc(2);
    chk("irq", 32'h0000_0000, 32'(irq));
    wr(`MPS_ADR_CTRL, 16'h0004);
    wr(`MPS_ADR_CTRL, 16'h0005);
    cyc(2);
    chk("outputs", 32'(6'h2A), 32'(outs));
    $display("test overload done");
    @(posedge clk_sys);
    cpl_en <= 1'b0;
    n = 0;
    while (led_run === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk_rng("watchdog", 42, 53, n);
    if (n == 200) end_sim();
    cyc(1);
    chk("outputs", 32'(6'h29), 32'(outs));
    rc("events", `MPS_ADR_EVT, 16'h000A);
    wr(`MPS_ADR_EVT, 16'h000A);
    rc("events", `MPS_ADR_EVT, 16'h0000);
    @(posedge clk_sys);
    cpl_en <= 1'b1;
    cyc(12);
    chk("outputs", 32'(6'h2A), 32'(outs));
    @(posedge clk_sys);
    cpl_gap <= 8'h2F;
    cyc(150);
    chk("outputs", 32'(6'h2A), 32'(outs));
    @(posedge clk_sys);
    cpl_gap <= 8'h07;
    $display("test watchdog done");
    wr(`MPS_ADR_PH2, 16'h0000);
    apply();
    rc("status", `MPS_ADR_STAT, 16'h000C);
    chk("coil", 32'h0000_0000, 32'(coil_drive_right));
    blink(240);
    chk_rng("flash", 36, 46, stop_tog);
    wr(`MPS_ADR_CTRL, 16'h0001);
    wr(`MPS_ADR_PH1, 16'h0000);
    apply();
    rc("status", `MPS_ADR_STAT, 16'h000C);
    $display("test fault done");
    setsw(4'h4, 4'h2);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    cyc(5);
    sp(1'b0, 8'h2A, 8'h2A, 8'h2A);
    chk("outputs", 32'(6'h02), 32'(outs));
    rc("phase1 after reset", `MPS_ADR_PH1, 16'h0000);
    $display("test second reset done");
    end_sim();
  end
endmodule : mps_top_tb_top
`default_nettype wire

/* File: verilog/mps_blink.sv */
// Half-period divider giving a blink level and a tick
`timescale 1ns/1ns
`default_nettype none
module mps_blink
  import mps_pkg::*;
#(
  parameter int unsigned HALF_CYC = 250_000
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  output var  logic lvl,
  output var  logic tick
);
  mps_blink_state_type s_reg;  // Registered state
  mps_blink_state_type s_next; // Next state
  localparam mps_cnt_type LAST = mps_cnt_type'(HALF_CYC - 1);

  // Count a half period, then toggle and tick
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == LAST) begin
      s_next.cnt  = '0;
      s_next.lvl  = ~s_reg.lvl;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  // Register, cleared on reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lvl  = s_reg.lvl;
  assign tick = s_reg.tick;

  a_blink_half: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_reg.cnt == LAST) |=> (tick && s_reg.cnt == '0 && lvl != $past(lvl)))
    else $error("blink divider half period wrong");
endmodule : mps_blink
`default_nettype wire

/* File: verilog/mps_top.sv */
// Motor protection status indicators, setpoint selection and coil drive
`timescale 1ns/1ns
`default_nettype none
`include "mps_cfg.svh"
module mps_top
  import mps_pkg::*;
#(
  parameter int unsigned WDOG_CYC  = `MPS_WDOG_MS * (`MPS_CLK_HZ / 1000),
  parameter int unsigned HALF_LOW  = `MPS_CLK_HZ / (2 * `MPS_OVL_LOW_HZ),
  parameter int unsigned HALF_HIGH = `MPS_CLK_HZ / (2 * `MPS_OVL_HIGH_HZ),
  parameter int unsigned HALF_FLK  = `MPS_CLK_HZ / (2 * `MPS_FLICK_HZ),
  parameter int unsigned HALF_SLOW = `MPS_CLK_HZ / (2 * `MPS_SLOW_HZ)
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [3:0]  sw_amp,
  input  wire logic [3:0]  sw_tenth,
  input  wire logic        overload_trip,
  input  wire logic        load_above_max,
  input  wire logic        load_below_min,
  input  wire logic        bus_frame_ok,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [15:0] reg_rdata,
  output var  logic        irq,
  output var  logic        coil_drive_right,
  output var  logic        coil_drive_left,
  output var  logic        led_motor_on,
  output var  logic        led_overload,
  output var  logic        led_run,
  output var  logic        led_stop,
  output var  logic        reg_mode,
  output var  mps_amp_type rated_current_phase_one,
  output var  mps_amp_type rated_current_phase_two,
  output var  mps_amp_type rated_current_phase_three
);
  // Divider slots
  localparam int BL_LOW  = 0;
  localparam int BL_HIGH = 1;
  localparam int BL_FLK  = 2;
  localparam int BL_SLOW = 3;
  localparam int unsigned HALFS [4] = '{HALF_LOW, HALF_HIGH, HALF_FLK, HALF_SLOW};
  localparam mps_cnt_type WDOG_LAST   = mps_cnt_type'(WDOG_CYC - 1);
  localparam logic [3:0]  FLICK_TICKS = 4'(`MPS_FLICK_S * 2 * `MPS_SLOW_HZ);
  localparam logic [3:0]  PAUSE_TICKS = 4'(`MPS_PAUSE_S * 2 * `MPS_SLOW_HZ);

  mps_state_type s_reg;       // Registered state
  mps_state_type s;           // Next state
  logic [3:0]    blink_lvl;   // Blink levels
  logic [3:0]    blink_tick;  // Half-period ticks
  mps_amp_type   sw_val;      // Switch setpoint
  logic [3:0]    ev_clr;      // Event clear mask
  logic [3:0]    ev_set;      // Event set mask
  logic [3:0]    target;      // Blinks to show
  logic          pause_done;  // Pause elapsed

  // Clamp a decimal digit
  function automatic logic [3:0] dig(input logic [3:0] d);
    return (d > `MPS_DIGIT_MAX) ? `MPS_DIGIT_MAX : d;
  endfunction : dig

  // Both switches to tenths of an ampere
  function automatic mps_amp_type sw_tenths(input logic [7:0] v);
    return 8'(dig(v[7:4]) * `MPS_TENTHS_PER_A) + 8'(dig(v[3:0]));
  endfunction : sw_tenths

  // Limit a written register value
  function automatic mps_amp_type sp_clamp(input logic [7:0] v);
    return (v > `MPS_REG_MAX) ? `MPS_REG_MAX : v;
  endfunction : sp_clamp

  // Four blink dividers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_blink
      mps_blink #(.HALF_CYC(HALFS[gi])) u_blink (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .lvl     (blink_lvl[gi]),
        .tick    (blink_tick[gi])
      );
    end
  endgenerate

  assign sw_val = sw_tenths(s_reg.sw_sync);

  // Next state
  always_comb begin
    s          = s_reg;
    ev_clr     = '0;
    ev_set     = '0;
    target     = '0;
    pause_done = 1'b0;
    // Two-stage switch synchroniser
    s.sw_meta = {sw_amp, sw_tenth};
    s.sw_sync = s_reg.sw_meta;
    // Apply countdown
    if (s_reg.apply_wait != 2'h0) begin
      s.apply_wait = 2'(s_reg.apply_wait - 1'b1);
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `MPS_ADR_CTRL: s.ctrl = mps_ctrl_type'(reg_wdata[$bits(mps_ctrl_type)-1:0]);
        `MPS_ADR_CMD: begin
          if (reg_wdata[`MPS_CMD_APPLY_BIT]) begin
            s.apply_wait = `MPS_APPLY_DLY;
          end
        end
        `MPS_ADR_PH1: s.regs.ph1 = sp_clamp(reg_wdata[7:0]);
        `MPS_ADR_PH2: s.regs.ph2 = sp_clamp(reg_wdata[7:0]);
        `MPS_ADR_PH3: s.regs.ph3 = sp_clamp(reg_wdata[7:0]);
        `MPS_ADR_EVT: ev_clr = reg_wdata[3:0];
        `MPS_ADR_MASK: s.mask = reg_wdata[3:0];
        default: ;
      endcase
    end
    // Setpoint apply, only at reset or command
    if (s_reg.apply_wait == 2'h1) begin
      s.reg_mode = (sw_val == '0);
      if (!s.reg_mode) begin
        // One switch value on all phases
        s.appl.ph1 = (sw_val < `MPS_SW_MIN) ? `MPS_SW_MIN : sw_val;
        s.appl.ph2 = s.appl.ph1;
        s.appl.ph3 = s.appl.ph1;
        s.fault    = 1'b0;
      end else if (s_reg.ctrl.single_phase) begin
        // Separate phase currents, extended range
        s.appl  = s_reg.regs;
        s.fault = (s_reg.regs.ph1 == '0) || (s_reg.regs.ph2 == '0)
               || (s_reg.regs.ph3 == '0);
      end else begin
        // First phase register for all phases
        s.appl.ph1 = s_reg.regs.ph1;
        s.appl.ph2 = s_reg.regs.ph1;
        s.appl.ph3 = s_reg.regs.ph1;
        s.fault    = (s_reg.regs.ph1 == '0);
      end
    end
    // Trip latch, released when both run commands drop
    s.trip = overload_trip || (s_reg.trip && (s.ctrl.run_right || s.ctrl.run_left));
    // Coil drive with interlock
    s.coil_r = s.ctrl.run_right && !s.ctrl.run_left && !s.trip && !s.fault;
    s.coil_l = s.ctrl.run_left && !s.ctrl.run_right && !s.trip && !s.fault;
    s.led.motor_on = s.coil_r || s.coil_l;
    s.warn = load_above_max && s.led.motor_on;
    // Overload indicator with priority
    if (s.trip) begin
      s.led.overload = 1'b1;
    end else if (s.warn) begin
      s.led.overload = blink_lvl[BL_HIGH];
    end else if (load_below_min && s.led.motor_on) begin
      s.led.overload = blink_lvl[BL_LOW];
    end else begin
      s.led.overload = 1'b0;
    end
    // Bus watchdog
    if (bus_frame_ok) begin
      s.wdog      = '0;
      s.comm_lost = 1'b0;
    end else if (s_reg.wdog == WDOG_LAST) begin
      s.comm_lost = 1'b1;
    end else begin
      s.wdog = s_reg.wdog + 1'b1;
    end
    s.led.run = !s.comm_lost;
    // Sticky events, set wins over clear
    ev_set = {s.warn && !s_reg.warn, s.fault && !s_reg.fault,
              s.comm_lost && !s_reg.comm_lost, s.trip && !s_reg.trip};
    s.events = (s_reg.events & ~ev_clr) | ev_set;
    s.irq    = |(s.events & s.mask);
    // Flash code sequencer on slow ticks
    target     = (s_reg.flash == FL_CODE) ? `MPS_ERR_CODE : `MPS_ERR_ARG;
    pause_done = blink_tick[BL_SLOW] && (s_reg.fcnt == PAUSE_TICKS - 1'b1);
    unique case (s_reg.flash)
      FL_IDLE: begin
        if (s.fault) begin
          s.flash = FL_FLICK;
          s.fcnt  = '0;
        end
      end
      FL_FLICK: begin
        if (blink_tick[BL_SLOW]) begin
          if (s_reg.fcnt == FLICK_TICKS - 1'b1) begin
            s.flash = FL_PAUSE1;
            s.fcnt  = '0;
          end else begin
            s.fcnt = s_reg.fcnt + 1'b1;
          end
        end
      end
      FL_PAUSE1, FL_PAUSE2, FL_PAUSE3: begin
        if (pause_done) begin
          s.fcnt = '0;
          s.fon  = 1'b1;
          if (s_reg.flash == FL_PAUSE1) begin
            s.flash = FL_CODE;
          end else if (s_reg.flash == FL_PAUSE3) begin
            s.flash = FL_FLICK;
            s.fon   = 1'b0;
          end else if (`MPS_ERR_ARG == 4'h0) begin
            s.flash = FL_PAUSE3;
            s.fon   = 1'b0;
          end else begin
            s.flash = FL_ARG;
          end
        end else if (blink_tick[BL_SLOW]) begin
          s.fcnt = s_reg.fcnt + 1'b1;
        end
      end
      FL_CODE, FL_ARG: begin
        if (blink_tick[BL_SLOW]) begin
          if (s_reg.fon) begin
            s.fon  = 1'b0;
            s.fcnt = s_reg.fcnt + 1'b1;
          end else if (s_reg.fcnt == target) begin
            s.fcnt  = '0;
            s.flash = (s_reg.flash == FL_CODE) ? FL_PAUSE2 : FL_PAUSE3;
          end else begin
            s.fon = 1'b1;
          end
        end
      end
      default: s.flash = FL_IDLE;
    endcase
    if (!s.fault) begin
      s.flash = FL_IDLE;
      s.fon   = 1'b0;
    end
    // Stop indicator
    if (s.fault) begin
      s.led.stop = (s.flash == FL_FLICK) ? blink_lvl[BL_FLK] : s.fon;
    end else begin
      s.led.stop = s.comm_lost;
    end
    // Register read, data one cycle later
    s.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `MPS_ADR_CTRL: s.rdata = 16'($unsigned(s_reg.ctrl));
        `MPS_ADR_PH1:  s.rdata = 16'(s_reg.regs.ph1);
        `MPS_ADR_PH2:  s.rdata = 16'(s_reg.regs.ph2);
        `MPS_ADR_PH3:  s.rdata = 16'(s_reg.regs.ph3);
        `MPS_ADR_STAT: s.rdata = 16'({s_reg.warn, s_reg.fault, s_reg.reg_mode,
                                      s_reg.comm_lost, s_reg.trip});
        `MPS_ADR_EVT:  s.rdata = 16'(s_reg.events);
        `MPS_ADR_MASK: s.rdata = 16'(s_reg.mask);
        default:       s.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_reg            <= '0;
      s_reg.apply_wait <= `MPS_APPLY_DLY;
    end else begin
      s_reg <= s;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata                 = s_reg.rdata;
  assign irq                       = s_reg.irq;
  assign coil_drive_right          = s_reg.coil_r;
  assign coil_drive_left           = s_reg.coil_l;
  assign led_motor_on              = s_reg.led.motor_on;
  assign led_overload              = s_reg.led.overload;
  assign led_run                   = s_reg.led.run;
  assign led_stop                  = s_reg.led.stop;
  assign reg_mode                  = s_reg.reg_mode;
  assign rated_current_phase_one   = s_reg.appl.ph1;
  assign rated_current_phase_two   = s_reg.appl.ph2;
  assign rated_current_phase_three = s_reg.appl.ph3;

  // Checks on registered state and outputs, one clock domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_switch_apply: assert property (
    (s_reg.apply_wait == 2'h1 && sw_val >= `MPS_SW_MIN)
      |=> (rated_current_phase_one == $past(sw_val)))
    else $error("switch setpoint not applied");
  a_switch_range: assert property (
    (!reg_mode && s_reg.apply_wait == 2'h0) |-> (rated_current_phase_one >= `MPS_SW_MIN
      && rated_current_phase_two == rated_current_phase_one
      && rated_current_phase_three == rated_current_phase_one))
    else $error("switch setpoint out of range");
  a_reg_single: assert property (
    (s_reg.apply_wait == 2'h1 && sw_val == '0 && s_reg.ctrl.single_phase)
      |=> (reg_mode && rated_current_phase_three == $past(s_reg.regs.ph3)))
    else $error("phase register not applied");
  a_no_current: assert property (
    (s_reg.apply_wait == 2'h1 && sw_val == '0 && s_reg.regs.ph1 == '0)
      |=> (s_reg.fault && !coil_drive_right && !coil_drive_left && s_reg.flash != FL_IDLE))
    else $error("missing setpoint not flagged");
  a_apply_hold: assert property (
    (s_reg.apply_wait == 2'h0 && !(reg_wr && reg_addr == `MPS_ADR_CMD))
      |=> $stable(s_reg.appl))
    else $error("setpoint changed without apply");
  a_coil_lock: assert property (
    !(coil_drive_right && coil_drive_left) && (led_motor_on == (coil_drive_right
      || coil_drive_left)))
    else $error("coil interlock or motor led broken");
  a_trip_off: assert property (
    overload_trip |=> (led_overload && !led_motor_on && !coil_drive_right))
    else $error("trip not shown");
  a_ovl_fast: assert property (
    (s_reg.warn && !s_reg.trip) |-> (led_overload == $past(blink_lvl[BL_HIGH])))
    else $error("overload blink wrong");
  a_ovl_dark: assert property (
    (!s_reg.trip && !led_motor_on) |-> !led_overload)
    else $error("overload led lit with motor off");
  a_wdog_expire: assert property (
    (s_reg.wdog == WDOG_LAST && !bus_frame_ok) |=> (!led_run ##1 !led_run || $past(bus_frame_ok)))
    else $error("watchdog did not expire");
  a_stop_steady: assert property (
    (s_reg.comm_lost && !s_reg.fault) |-> (led_stop && !led_run))
    else $error("stop led not steady");
  a_flash_order: assert property (
    (s_reg.flash == FL_PAUSE1) |=> (s_reg.flash inside {FL_PAUSE1, FL_CODE, FL_IDLE}))
    else $error("flash sequence order wrong");

  // Slow blink while below minimum load with the motor on
  a_ovl_slow: assert property (
    (!s_reg.trip && !s_reg.warn && led_motor_on && $past(load_below_min))
      |-> (led_overload == $past(blink_lvl[BL_LOW])))
    else $error("minimum load blink wrong");
  // Flash code drives the stop led once the flicker is over
  a_stop_flash: assert property (
    (s_reg.fault && s_reg.flash != FL_FLICK) |-> (led_stop == s_reg.fon))
    else $error("stop led not following flash code");
  // Stop led dark while the bus runs and no fault is present
  a_stop_dark: assert property (
    (!s_reg.fault && !s_reg.comm_lost) |-> !led_stop)
    else $error("stop led lit with bus running");
  // A good frame lights the run led on the next edge
  a_run_recover: assert property (
    bus_frame_ok |=> led_run)
    else $error("run led not restored by frame");
endmodule : mps_top
`default_nettype wire
